// [seq_pkg.sv]
// constants, register layout and types for the controlled parameter-set sequencer
package seq_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] COUNT_OFS  = 8'h04;
  localparam logic [7:0] SELECT_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS    = 8'h0c;
  localparam logic [7:0] ACTIVE_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // command bits, select layout, status layout
  localparam int CMD_STORE_BIT    = 0;
  localparam int CMD_ADVANCE_BIT  = 1;
  localparam int SEL_REPEAT_LSB   = 8;
  localparam int STAT_WAIT_BIT    = 8;
  localparam int STAT_ON_BIT      = 9;

  // set sizing and reset values
  localparam int             MAX_SETS       = 64;
  localparam logic [6:0]     COUNT_RESET    = 7'h01;
  localparam logic [8:0]     REPEAT_RESET   = 9'h001;

  // settle window on the control lines, 1 us at 200 MHz
  localparam int CLK_MHZ     = 200;
  localparam int SETTLE_NS   = 1000;
  localparam int SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {SRC_ALWAYS, SRC_LINE, SRC_OFF} advance_policy_t;

  // control register: {invert[3:0], restart_en, restart_line, advance_line, policy, on}
  typedef struct packed {
    logic [3:0]      line_invert;
    logic            restart_en;
    logic [1:0]      restart_line;
    logic [1:0]      advance_line;
    advance_policy_t advance_policy;
    logic            sequencer_on;
  } ctrl_t;

endpackage

// [set_sequencer.sv]
// controlled parameter-set sequencer with apb register access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module set_sequencer #(
  parameter int PARAM_W = 32,
  parameter int ADDR_W  = 8
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // pins: frame trigger and the four input lines
  input  wire logic               frame_trigger,
  input  wire logic [3:0]         in_lines,
  // active set toward the sensor
  output logic [PARAM_W-1:0]      active_value,
  output logic [5:0]              active_index,
  output logic                    set_loaded,
  output logic                    frame_go,
  output logic                    waiting_trigger
);
  import seq_pkg::*;

  // settle reload in clocks; nine bits hold the 1 us window at this clock
  localparam logic [8:0] SETTLE_LD = 9'(SETTLE_CYC);

  // parameter-set storage
  logic [PARAM_W-1:0] set_val    [MAX_SETS];
  logic [8:0]         set_repeat [MAX_SETS];

  // registers
  ctrl_t              ctrl_q, ctrl_d;
  logic [6:0]         count_q, count_d;
  logic [5:0]         sel_q, sel_d;
  logic [8:0]         repeat_q, repeat_d;
  logic [PARAM_W-1:0] active_q, active_d;
  logic [PARAM_W-1:0] backup_q, backup_d;
  logic [5:0]         idx_q, idx_d;
  logic [8:0]         settle_q, settle_d;
  logic               loaded_q, loaded_d;
  logic               go_q, go_d;

  // synchronisers: stage 1 feeds stage 2 only, stage 3 is for edge and change detection
  logic [4:0] sync1_q, sync2_q, sync3_q;
  logic [4:0] pin_raw;

  // decoded strobes, line levels and the next index
  logic        wr, rd, store_cmd, adv_cmd, trig_edge, accept;
  logic [3:0]  lvl, lvl_old;
  logic        adv_lvl, rst_lvl, line_moving, store_en;
  logic [5:0]  next_idx;

  // apb decode; pready always high, so every access is zero wait
  assign wr        = psel & penable & pwrite;
  assign rd        = psel & penable & ~pwrite;
  assign pready    = 1'b1;
  assign store_cmd = wr && paddr == CMD_OFS && pwdata[CMD_STORE_BIT];
  assign adv_cmd   = wr && paddr == CMD_OFS && pwdata[CMD_ADVANCE_BIT];

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a == CTRL_OFS || a == COUNT_OFS || a == SELECT_OFS ||
             a == CMD_OFS || a == ACTIVE_OFS || a == STATUS_OFS;
  endfunction

  // a watched line moved between the last two synchronised samples
  function automatic logic line_flip(input logic [3:0] cur, input logic [3:0] prv,
                                     input logic [1:0] pick);
    line_flip = cur[pick] != prv[pick];
  endfunction

  // line levels after invert, on synchronised copies only
  // invert acts after the flops, so changing it never looks like a line edge
  assign lvl     = sync2_q[3:0] ^ ctrl_q.line_invert;
  assign lvl_old = sync3_q[3:0] ^ ctrl_q.line_invert;
  assign adv_lvl = lvl[ctrl_q.advance_line];
  assign rst_lvl = ctrl_q.restart_en & lvl[ctrl_q.restart_line];
  assign line_moving =
    (ctrl_q.advance_policy == SRC_LINE && line_flip(lvl, lvl_old, ctrl_q.advance_line)) ||
    (ctrl_q.restart_en && line_flip(lvl, lvl_old, ctrl_q.restart_line));

  // a trigger counts only while waiting; one landing in the settle window is dropped
  assign trig_edge       = sync2_q[4] & ~sync3_q[4];
  assign waiting_trigger = ctrl_q.sequencer_on & ~line_moving & (settle_q == 9'h000);
  assign accept          = trig_edge & waiting_trigger;

  // ascending order with wrap at the configured count
  // a count of one keeps the index at zero
  assign next_idx = ({1'b0, idx_q} == count_q - 7'h01) ? 6'h00 : idx_q + 6'h01;

  // store only while stopped, so a set never changes under the sequencer
  assign store_en = store_cmd & ~ctrl_q.sequencer_on;

  // configuration registers; reserved bits are dropped on write
  always_comb
  begin
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    sel_d    = sel_q;
    repeat_d = repeat_q;
    if (wr)
    begin
      unique case (paddr)
        CTRL_OFS:   ctrl_d = ctrl_t'(pwdata[11:0]);
        COUNT_OFS:
        begin
          // clamp into 1..64; the full word is checked first so large values saturate
          if (pwdata > 32'(MAX_SETS))
            count_d = 7'(MAX_SETS);
          else if (pwdata[6:0] == 7'h00)
            count_d = 7'h01;
          else
            count_d = pwdata[6:0];
        end
        SELECT_OFS:
        begin
          sel_d    = pwdata[5:0];
          repeat_d = pwdata[SEL_REPEAT_LSB +: 9];
        end
        default:    ;
      endcase
    end
  end

  // configuration flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= '0;
      count_q  <= COUNT_RESET;
      sel_q    <= 6'h00;
      repeat_q <= REPEAT_RESET;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      sel_q    <= sel_d;
      repeat_q <= repeat_d;
    end
  end

  // sequencing: enable, disable, accepted trigger, then software advance
  // the count is not checked against the index while cycling, so keep it
  // fixed while the sequencer is on
  always_comb
  begin
    active_d = active_q;
    backup_d = backup_q;
    idx_d    = idx_q;
    loaded_d = 1'b0;
    go_d     = accept;
    // user writes to the active value are taken on or off, unless a frame trigger loads a set in the same clock
    if (wr && paddr == ACTIVE_OFS)
      active_d = pwdata[PARAM_W-1:0];
    // enable: remember the user values, start the cycle at set 0
    if (ctrl_d.sequencer_on && !ctrl_q.sequencer_on)
    begin
      backup_d = active_d;
      active_d = set_val[0];
      idx_d    = 6'h00;
      loaded_d = 1'b1;
    end
    // disable: stop and put the user values back
    else if (!ctrl_d.sequencer_on && ctrl_q.sequencer_on)
    begin
      active_d = backup_q;
      idx_d    = 6'h00;
    end
    // frame trigger: restart first, then the selected advance source
    else if (ctrl_q.sequencer_on && accept)
    begin
      if (rst_lvl)
      begin
        idx_d    = 6'h00;
        active_d = set_val[0];
        loaded_d = 1'b1;
      end
      else if (ctrl_q.advance_policy == SRC_ALWAYS ||
               (ctrl_q.advance_policy == SRC_LINE && adv_lvl))
      begin
        idx_d    = next_idx;
        active_d = set_val[next_idx];
        loaded_d = 1'b1;
      end
    end
    // software advance steps only when no control source is selected
    else if (ctrl_q.sequencer_on && adv_cmd && ctrl_q.advance_policy == SRC_OFF)
    begin
      idx_d    = next_idx;
      active_d = set_val[next_idx];
      loaded_d = 1'b1;
    end
  end

  // active set flops; the pulses last exactly one clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_q <= '0;
      backup_q <= '0;
      idx_q    <= 6'h00;
      loaded_q <= 1'b0;
      go_q     <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      backup_q <= backup_d;
      idx_q    <= idx_d;
      loaded_q <= loaded_d;
      go_q     <= go_d;
    end
  end

  // settle window: reload on any watched line change, then count down to zero
  // a bouncing line reloads the window rather than extending a stale one
  always_comb
  begin
    settle_d = (settle_q != 9'h000) ? settle_q - 9'h001 : 9'h000;
    if (line_moving)
      settle_d = SETTLE_LD;
  end

  // settle counter flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_q <= 9'h000;
    else
      settle_q <= settle_d;
  end

  // pins are asynchronous: two flops before any logic reads them
  // stage 3 only feeds the edge and change detectors
  assign pin_raw = {frame_trigger, in_lines};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // set storage has no reset; store is refused while cycling so sets stay stable
  // a store issued while cycling is dropped rather than queued
  always_ff @(posedge pclk)
  begin
    if (store_en)
    begin
      set_val[sel_q]    <= active_q;
      set_repeat[sel_q] <= repeat_q;
    end
  end

  // unmapped addresses answer with pslverr and zero read data
  assign pslverr = psel & penable & ~mapped(paddr);

  // read data; zero outside the access phase of a read
  always_comb
  begin
    prdata  = 32'h0000_0000;
    if (rd)
    begin
      unique case (paddr)
        CTRL_OFS:   prdata = {20'h00000, ctrl_q};
        COUNT_OFS:  prdata = {25'h0000000, count_q};
        SELECT_OFS: prdata = {15'h0000, set_repeat[sel_q], 2'b00, sel_q};
        ACTIVE_OFS: prdata = 32'(active_q);
        STATUS_OFS:
        begin
          prdata                = {26'h0000000, idx_q};
          prdata[STAT_WAIT_BIT] = waiting_trigger;
          prdata[STAT_ON_BIT]   = ctrl_q.sequencer_on;
        end
        default:    prdata = 32'h0000_0000;
      endcase
    end
  end

  // outputs toward the datapath come from flops
  assign active_value = active_q;
  assign active_index = idx_q;
  assign set_loaded   = loaded_q;
  assign frame_go     = go_q;

endmodule // set_sequencer

// [seq_chk.sv]
// port assertions for the sequencer
`timescale 1ns/1ps
module seq_chk (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // trigger side
  input wire logic        frame_trigger,
  input wire logic [5:0]  active_index,
  input wire logic        set_loaded,
  input wire logic        frame_go,
  input wire logic        waiting_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pin edge reaches the core after two flops
  sequence trig_seen;
    $past(frame_trigger, 2);
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_map: assert property (psel && penable |->
    pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
  a_rd_idle: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata");
  a_go_pulse: assert property (frame_go |=> !frame_go) else $error("go too long");
  a_load_pulse: assert property (set_loaded |=> !set_loaded) else $error("load too long");
  a_go_wait: assert property (frame_go |-> $past(waiting_trigger)) else $error("go");
  a_go_trig: assert property (frame_go |-> trig_seen) else $error("go no trig");
  a_index_step: assert property ($changed(active_index) && active_index != 6'h0 |->
    set_loaded && active_index == $past(active_index) + 6'h1) else $error("index step");
endmodule // seq_chk
bind set_sequencer seq_chk seq_chk_inst (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .frame_trigger, .active_index, .set_loaded, .frame_go, .waiting_trigger);

// [line_src.sv]
// frame trigger and input line source facing the sequencer pins
`timescale 1ns/1ps
module line_src (
  // clock and device status
  input wire logic  pclk,
  input wire logic  waiting_trigger,
  // pins toward the device
  output logic       frame_trigger,
  output logic [3:0] in_lines
);
  localparam int HOLD_CYC = 210; // 1 us plus margin
  // idle pins at time zero
  initial
  begin
    frame_trigger = 1'b0;
    in_lines = 4'h0;
  end
  // one frame; settle=0 breaks the setup window on purpose
  task automatic fire(input logic [3:0] lines, input bit settle);
    @(posedge pclk);
    in_lines <= lines;
    repeat (settle ? HOLD_CYC : 3) @(posedge pclk);
    if (settle)
      wait (waiting_trigger === 1'b1);
    @(posedge pclk);
    frame_trigger <= 1'b1;
    repeat (8) @(posedge pclk);
    frame_trigger <= 1'b0;
    repeat (HOLD_CYC) @(posedge pclk);
  endtask
endmodule // line_src

// [tb_top.sv]
// self-checking bench for the parameter-set sequencer
`timescale 1ns/1ps
module tb_top;
  import seq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic        frame_trigger, set_loaded, frame_go, waiting_trigger;
  logic [7:0]  paddr;
  logic [3:0]  in_lines;
  logic [5:0]  active_index;
  logic [31:0] pwdata, prdata, rv, active_value, orig;
  logic [31:0] sv [3];
  logic [37:0] exp_q [$];
  int          fails, cmp_count;
  set_sequencer set_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .frame_trigger, .in_lines, .active_value, .active_index,
    .set_loaded, .frame_go, .waiting_trigger);
  line_src line_src_inst (.pclk, .waiting_trigger, .frame_trigger, .in_lines);
  // 200 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [37:0] e, input logic [37:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({6'h0, e}, {6'h0, rv});
  endtask
  // note the expected set, then let the far side send the frame
  task automatic frame(input logic [3:0] l, input logic [5:0] i);
    exp_q.push_back({i, sv[i]});
    line_src_inst.fire(l, 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // an unexpected frame meets an impossible index
  always @(posedge pclk)
    if (frame_go === 1'b1)
      chk(exp_q.size() ? exp_q.pop_front() : 38'h3f_0000_0000, {active_index, active_value});
  // hang guard, well past the longest run
  initial
  begin
    repeat (40000) @(posedge pclk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    presetn = 1'b0;
    void'($urandom(88));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    orig = $urandom;
    apb(1'b1, COUNT_OFS, 32'h80);
    rd(COUNT_OFS, 32'h40);
    apb(1'b1, COUNT_OFS, 32'h3);
    rd(COUNT_OFS, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      sv[i] = $urandom;
      apb(1'b1, ACTIVE_OFS, sv[i]);
      apb(1'b1, SELECT_OFS, 32'(i) | 32'h100);
      apb(1'b1, CMD_OFS, 32'h1);
    end
    apb(1'b1, ACTIVE_OFS, orig);
    apb(1'b0, 8'h18, 32'h0);
    chk(38'h1, {37'h0, ev});
    $display("test registers done");
    apb(1'b1, CTRL_OFS, 32'hc1);
    rd(ACTIVE_OFS, sv[0]);
    frame(4'h0, 6'h1);
    frame(4'h0, 6'h2);
    frame(4'h0, 6'h0);
    frame(4'h0, 6'h1);
    frame(4'h4, 6'h0);
    frame(4'h0, 6'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    rd(ACTIVE_OFS, orig);
    $display("test always source done");
    apb(1'b1, CTRL_OFS, 32'hb);
    frame(4'h0, 6'h0);
    frame(4'h2, 6'h1);
    line_src_inst.fire(4'h0, 1'b0);
    frame(4'h2, 6'h2);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h20b);
    frame(4'h2, 6'h0);
    frame(4'h0, 6'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    $display("test line source done");
    apb(1'b1, CTRL_OFS, 32'h5);
    frame(4'h2, 6'h0);
    apb(1'b1, CMD_OFS, 32'h2);
    rd(STATUS_OFS, 32'h301);
    frame(4'h2, 6'h1);
    chk(38'h0, 38'(exp_q.size()));
    $display("test software advance done");
    tally_and_finish;
  end
endmodule // tb_top
